// [dv/testbench.sv]
// Self-checking testbench of the operating-state sequencer.
`timescale 1ns/10ps
module testbench;
    localparam int FR = 4;
    localparam int XT = 8;
    logic clk = 1'b0, resetn = 1'b0, supply_main_good = 1'b0, supply_secondary_good = 1'b0;
    logic device_reset_n = 1'b0, wakeup_pin = 1'b0, host_select_n = 1'b1;
    logic auto_idle_after_boot = 1'b0, cmd_valid = 1'b0;
    logic [4:0] cmd_code = 5'h00;
    logic [15:0] sleep_terminal = 16'h0003;
    logic restore_done, pll_locked, tx_blocks_ready, tx_done, rx_blocks_ready, rx_packet_done;
    logic rx_timeout, delay_expired, slow_tick, core_power_en, regulator_en, core_reset_n;
    logic always_on_reset_n, external_enable_out, fast_oscillator_en, xtal_en, host_link_slow;
    logic store_download, pll_en, tx_power_en, tx_active, rx_power_en, rx_active;
    logic sleep_counter_en, fast_oscillator_ready, xtal_ready;
    logic [3:0] state_out;
    logic [1:0] clk_select;
    logic [31:0] rng = 32'h000108D2;
    logic [4:0] code;
    int mismatches = 0;
    int num_checks = 0;
    uos_sequencer #(.FAST_OSCILLATOR_CYCLES(FR), .XTAL_CYCLES(XT)) u_uos_sequencer (.*);
    uos_far_model u_uos_far_model (.*);
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] exp_state(input logic [4:0] c);
        case (c)
            uos_pkg::CMD_TX_NOW, uos_pkg::CMD_DELAYED_TX: return 8'h05;
            uos_pkg::CMD_RX_ENABLE, uos_pkg::CMD_DELAYED_RX: return 8'h07;
            uos_pkg::CMD_SLEEP: return 8'h09;
            uos_pkg::CMD_DEEP_DOZE: return 8'h0A;
            default: return 8'h04;
        endcase
    endfunction
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A state that never arrives ends the run here rather than hanging it.
    task automatic wait_state(input logic [3:0] s, input int lim);
        int n;
        n = 0;
        while (state_out !== s && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (state_out !== s) begin
            check("state_out wait", 8'(s), 8'(state_out));
            end_sim();
        end
    endtask
    task automatic send(input logic [4:0] c);
        cmd_valid = 1'b1;
        cmd_code = c;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("core_reset_n", 8'h00, 8'(core_reset_n));
        check("regulator_en", 8'h00, 8'(regulator_en));
        supply_main_good = 1'b1;
        repeat (2) @(negedge clk);
        check("external_enable_out", 8'h01, 8'(external_enable_out));
        check("fast_oscillator_en", 8'h01, 8'(fast_oscillator_en));
        check("xtal_en", 8'h01, 8'(xtal_en));
        supply_secondary_good = 1'b1;
        @(negedge clk);
        check("fast_oscillator_ready early", 8'h00, 8'(fast_oscillator_ready));
        repeat (FR + 2) @(negedge clk);
        check("fast_oscillator_ready", 8'h01, 8'(fast_oscillator_ready));
        repeat (XT - FR) @(negedge clk);
        check("xtal_ready", 8'h01, 8'(xtal_ready));
        device_reset_n = 1'b1;
        @(negedge clk);
        check("state_out boot", 8'h01, 8'(state_out));
        wait_state(4'h2, 20);
        send(uos_pkg::CMD_TX_NOW);
        check("state_out refused", 8'h02, 8'(state_out));
        auto_idle_after_boot = 1'b1;
        wait_state(4'h4, 40);
        for (int i = 0; i < 72; i++) begin
            rng = xs(rng);
            code = (i < 32) ? 5'(i) : rng[4:0];
            sleep_terminal = {14'h0000, rng[12:11]} + 16'h0001;
            send(code);
            check("state_out command", exp_state(code), 8'(state_out));
            check("tx_power_en", 8'(exp_state(code) == 8'h05), 8'(tx_power_en));
            check("rx_power_en", 8'(exp_state(code) == 8'h07), 8'(rx_power_en));
            // Abort lands in the same cycle as the blocks report ready, so it must win.
            if (rng[13] && exp_state(code) inside {8'h05, 8'h07}) begin
                @(negedge clk);
                send(uos_pkg::CMD_TRX_OFF);
                check("state_out abort", 8'h04, 8'(state_out));
            end
            if (code == uos_pkg::CMD_DEEP_DOZE) begin
                repeat (rng[7:5]) @(negedge clk);
                wakeup_pin = rng[8];
                host_select_n = rng[8] | !rng[9];
                device_reset_n = rng[8] | rng[9];
                @(negedge clk);
                wakeup_pin = 1'b0;
                host_select_n = 1'b1;
                device_reset_n = 1'b1;
                check("state_out wake", 8'h01, 8'(state_out));
            end
            wait_state(4'h4, 300);
            repeat (rng[10:9]) @(negedge clk);
        end
        supply_main_good = 1'b0;
        wait_state(4'h0, 5);
        check("external_enable_out off", 8'h00, 8'(external_enable_out));
        end_sim();
    end
endmodule // testbench
bind uos_sequencer uos_props u_uos_props (
    .clk(clk), .resetn(resetn), .supply_main_good(supply_main_good),
    .supply_secondary_good(supply_secondary_good), .device_reset_n(device_reset_n),
    .auto_idle_after_boot(auto_idle_after_boot), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .restore_done(restore_done), .pll_locked(pll_locked), .tx_done(tx_done),
    .rx_packet_done(rx_packet_done), .rx_timeout(rx_timeout), .state_out(state_out),
    .core_power_en(core_power_en), .regulator_en(regulator_en), .core_reset_n(core_reset_n),
    .always_on_reset_n(always_on_reset_n), .external_enable_out(external_enable_out),
    .clk_select(clk_select), .host_link_slow(host_link_slow), .store_download(store_download),
    .pll_en(pll_en), .sleep_counter_en(sleep_counter_en), .tx_power_en(tx_power_en),
    .tx_active(tx_active), .rx_power_en(rx_power_en), .rx_active(rx_active)
);

// [dv/uos_far_model.sv]
// Behavioural model of the analog blocks and restore logic around the sequencer.
`timescale 1ns/10ps
module uos_far_model (
    input wire logic clk,
    input wire logic store_download,
    input wire logic pll_en,
    input wire logic tx_power_en,
    input wire logic tx_active,
    input wire logic rx_power_en,
    input wire logic rx_active,
    input wire logic sleep_counter_en,
    output logic restore_done = 1'b0,
    output logic pll_locked = 1'b0,
    output logic tx_blocks_ready = 1'b0,
    output logic tx_done = 1'b0,
    output logic rx_blocks_ready = 1'b0,
    output logic rx_packet_done = 1'b0,
    output logic rx_timeout = 1'b0,
    output logic delay_expired = 1'b0,
    output logic slow_tick = 1'b0
);
    // A free divider staggers every answer except the block-ready flags so that slow responses are seen too.
    logic [2:0] div_reg = 3'h0;
    always @(posedge clk) begin
        div_reg <= div_reg + 3'h1;
        restore_done <= store_download && div_reg[0];
        pll_locked <= pll_en && (pll_locked || div_reg == 3'h7);
        tx_blocks_ready <= tx_power_en;
        rx_blocks_ready <= rx_power_en;
        delay_expired <= (tx_power_en || rx_power_en) && div_reg[1];
        tx_done <= tx_active && div_reg[0];
        rx_packet_done <= rx_active && div_reg[2:1] == 2'h1;
        rx_timeout <= rx_active && div_reg[2:1] == 2'h3;
        slow_tick <= sleep_counter_en && div_reg == 3'h0;
    end
endmodule // uos_far_model

// [dv/uos_props.sv]
// Concurrent checks on the ports of the operating-state sequencer.
`timescale 1ns/10ps
module uos_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_main_good,
    input wire logic supply_secondary_good,
    input wire logic device_reset_n,
    input wire logic auto_idle_after_boot,
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_code,
    input wire logic restore_done,
    input wire logic pll_locked,
    input wire logic tx_done,
    input wire logic rx_packet_done,
    input wire logic rx_timeout,
    input wire logic [3:0] state_out,
    input wire logic core_power_en,
    input wire logic regulator_en,
    input wire logic core_reset_n,
    input wire logic always_on_reset_n,
    input wire logic external_enable_out,
    input wire logic [1:0] clk_select,
    input wire logic host_link_slow,
    input wire logic store_download,
    input wire logic pll_en,
    input wire logic sleep_counter_en,
    input wire logic tx_power_en,
    input wire logic tx_active,
    input wire logic rx_power_en,
    input wire logic rx_active
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Supplies, reset and commands can all override a transition, so they are held out.
    logic quiet;
    assign quiet = supply_main_good && supply_secondary_good && device_reset_n && !cmd_valid;
    sequence s_tx_end;
        state_out == 4'h6 && tx_done && quiet;
    endsequence
    sequence s_rx_end;
        state_out == 4'h8 && (rx_packet_done || rx_timeout) && quiet;
    endsequence
    a_off_core_held: assert property (
        state_out == 4'h0 |-> !core_reset_n && !core_power_en && !regulator_en)
        else $error("core not held off in off state");
    a_boot_slow_link: assert property (
        state_out == 4'h1 |-> clk_select == 2'h1 && host_link_slow && store_download)
        else $error("boot state clocking or download wrong");
    a_idle_pll_clock: assert property (
        state_out == 4'h4 |-> clk_select == 2'h2 && pll_en)
        else $error("synthesizer idle not on pll clock");
    a_tx_end_return: assert property (s_tx_end |=> state_out == 4'h4)
        else $error("no return to synthesizer idle after transmit");
    a_rx_end_return: assert property (s_rx_end |=> state_out == 4'h4)
        else $error("no return to synthesizer idle after receive");
    a_sleep_slow_clock: assert property (
        state_out == 4'h9 |-> clk_select == 2'h3 && sleep_counter_en)
        else $error("sleep counter not on slow clock");
    a_doze_clock_off: assert property (
        state_out == 4'hA |-> clk_select == 2'h0 && !pll_en)
        else $error("clock running in deep doze");
    a_power_on_enable: assert property (
        supply_main_good ##1 supply_main_good |-> always_on_reset_n && external_enable_out)
        else $error("enable not raised after main supply");
    a_boot_after_restore: assert property (
        state_out == 4'h1 && quiet |-> ##1 (state_out == 4'h2) == $past(restore_done))
        else $error("boot left without restore or stuck after it");
    a_pll_lock_wait: assert property (
        state_out == 4'h3 && !pll_locked |=> state_out != 4'h4)
        else $error("synthesizer idle entered before lock");
    a_illegal_cmd_kept: assert property (
        state_out == 4'h2 && cmd_valid && cmd_code == uos_pkg::CMD_TX_NOW
        && !auto_idle_after_boot && supply_main_good && supply_secondary_good && device_reset_n
        |=> state_out == 4'h2)
        else $error("illegal command changed state");
    a_idle_osc_clock: assert property (
        state_out == 4'h2 |-> clk_select == 2'h1 && !pll_en)
        else $error("oscillator idle not on fast_oscillator clock");
    a_tx_wait_power: assert property (
        state_out == 4'h5 |-> tx_power_en && !tx_active && !rx_power_en)
        else $error("transmit blocks not powered in transmit preparation");
    a_rx_wait_power: assert property (
        state_out == 4'h7 |-> rx_power_en && !rx_active && !tx_power_en)
        else $error("receive blocks not powered in receive preparation");
endmodule // uos_props

// [rtl/uos_pkg.sv]
// Package of states, commands and timing constants for the operating-state sequencer.
package uos_pkg;
    // --------------------------------------------------------------------
    // Operating states
    // --------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_OFF, ST_BOOT_SLOW, ST_IDLE_OSCILLATOR, ST_PLL_WAIT, ST_IDLE_PLL,
        ST_TX_WAIT, ST_TX, ST_RX_WAIT, ST_RX, ST_SLEEP, ST_DEEP_DOZE
    } uos_state_t;
    // --------------------------------------------------------------------
    // Clock source selection
    // --------------------------------------------------------------------
    localparam logic [1:0] CLK_NONE = 2'h0;
    localparam logic [1:0] CLK_FAST_OSCILLATOR = 2'h1;
    localparam logic [1:0] CLK_PLL = 2'h2;
    localparam logic [1:0] CLK_SLOW_RC = 2'h3;
    // --------------------------------------------------------------------
    // Host fast command codes
    // --------------------------------------------------------------------
    localparam int CMD_W = 5;
    localparam logic [4:0] CMD_TX_NOW = 5'h01;
    localparam logic [4:0] CMD_RX_ENABLE = 5'h02;
    localparam logic [4:0] CMD_DELAYED_TX = 5'h03;
    localparam logic [4:0] CMD_DELAYED_RX = 5'h04;
    localparam logic [4:0] CMD_TRX_OFF = 5'h05;
    localparam logic [4:0] CMD_SLEEP = 5'h06;
    localparam logic [4:0] CMD_DEEP_DOZE = 5'h07;
    // --------------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------------
    localparam int CLK_MHZ = 40;
    localparam int FAST_OSCILLATOR_TIME_US = 500;
    localparam int XTAL_TIME_US = 1000;
    localparam int FAST_OSCILLATOR_CYCLES = FAST_OSCILLATOR_TIME_US * CLK_MHZ;
    localparam int XTAL_CYCLES = XTAL_TIME_US * CLK_MHZ;
    localparam int SLEEP_W = 16;
    localparam logic [15:0] SLEEP_TERM_RESET = 16'h0100;
    localparam int TIMER_W = 16;
endpackage

// [rtl/uos_sequencer.sv]
// Operating-state sequencer of the ultra-wideband transceiver.
`timescale 1ns/10ps
// Operation
// - OFF keeps core unpowered, regulator off, internal reset low.
// - Boot runs from 30 MHz RC, slow host link, restores store, then idles.
// - Oscillator idle clocks system near 120 MHz for full-speed host link.
// - Synthesizer idle clocks system from the PLL at 124.8 MHz.
// - Transmit preparation sequences transmit blocks on; serves delayed transmit.
// - Active transmit returns to synthesizer idle when transmission finishes.
// - Receive preparation sequences receive blocks on; serves delayed receive.
// - Active receive returns to synthesizer idle on packet or timeout.
// - Sleep clocks the sleep counter from slow RC, rest low-power.
// - Deep doze selects no clock and stops the PLL, oscillators stay enabled; wake on wake pin, host select, reset.
// - Supply above power-on threshold releases always-on block and raises enable.
// - Secondary supplies good start fast oscillator by 500 us, crystal by 1 ms.
// - Digital reset release enters boot; idle only after configuration restored.
// - Auto-idle bit enables PLL, waits for lock, then synthesizer idle.
// - Host fast commands, up to 32 codes, change the operating state.
module uos_sequencer #(
    parameter int FAST_OSCILLATOR_CYCLES = uos_pkg::FAST_OSCILLATOR_CYCLES,
    parameter int XTAL_CYCLES = uos_pkg::XTAL_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_main_good,
    input wire logic supply_secondary_good,
    input wire logic device_reset_n,
    input wire logic wakeup_pin,
    input wire logic host_select_n,
    input wire logic auto_idle_after_boot,
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_code,
    input wire logic restore_done,
    input wire logic pll_locked,
    input wire logic tx_blocks_ready,
    input wire logic tx_done,
    input wire logic rx_blocks_ready,
    input wire logic rx_packet_done,
    input wire logic rx_timeout,
    input wire logic delay_expired,
    input wire logic slow_tick,
    input wire logic [15:0] sleep_terminal,
    output logic [3:0] state_out,
    output logic core_power_en,
    output logic regulator_en,
    output logic core_reset_n,
    output logic always_on_reset_n,
    output logic external_enable_out,
    output logic fast_oscillator_en,
    output logic xtal_en,
    output logic [1:0] clk_select,
    output logic host_link_slow,
    output logic store_download,
    output logic pll_en,
    output logic tx_power_en,
    output logic tx_active,
    output logic rx_power_en,
    output logic rx_active,
    output logic sleep_counter_en,
    output logic fast_oscillator_ready,
    output logic xtal_ready
);
    // --------------------------------------------------------------------
    // State record
    // --------------------------------------------------------------------
    typedef struct packed {
        uos_pkg::uos_state_t state;
        logic delayed;
        logic [uos_pkg::TIMER_W-1:0] rc_timer;
        logic [uos_pkg::TIMER_W-1:0] xt_timer;
        logic [uos_pkg::SLEEP_W-1:0] sleep_cnt;
        logic aon_released;
        logic ext_en;
        logic rc_ready;
        logic xt_ready;
        logic [3:0] state_out;
        logic core_power_en;
        logic core_reset_n;
        logic [1:0] clk_select;
        logic host_link_slow;
        logic store_download;
        logic pll_en;
        logic tx_power_en;
        logic tx_active;
        logic rx_power_en;
        logic rx_active;
        logic sleep_counter_en;
    } uos_regs_t;

    uos_regs_t r_reg;
    uos_regs_t r_next;

    localparam logic [15:0] RC_LAST = 16'(FAST_OSCILLATOR_CYCLES - 1);
    localparam logic [15:0] XT_LAST = 16'(XTAL_CYCLES - 1);

    function automatic logic cmd_is(input logic v, input logic [4:0] c, input logic [4:0] k);
        cmd_is = v && (c == k);
    endfunction

    // --------------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.aon_released = supply_main_good;
        r_next.ext_en = supply_main_good;
        // Oscillator start-up timers; ready flags rise within the stated limits.
        if (!r_reg.aon_released || !supply_secondary_good) begin
            r_next.rc_timer = '0;
            r_next.xt_timer = '0;
            r_next.rc_ready = 1'b0;
            r_next.xt_ready = 1'b0;
        end else begin
            if (r_reg.rc_timer == RC_LAST) begin
                r_next.rc_ready = 1'b1;
            end else begin
                r_next.rc_timer = r_reg.rc_timer + 16'h0001;
            end
            if (r_reg.xt_timer == XT_LAST) begin
                r_next.xt_ready = 1'b1;
            end else begin
                r_next.xt_timer = r_reg.xt_timer + 16'h0001;
            end
        end
        // The sequencer starts only once the fast oscillator clocks the core.
        if (!r_reg.aon_released || !supply_secondary_good) begin
            r_next.state = uos_pkg::ST_OFF;
        end else begin
            case (r_reg.state)
                uos_pkg::ST_OFF: begin
                    if (r_reg.rc_ready && device_reset_n) begin
                        r_next.state = uos_pkg::ST_BOOT_SLOW;
                    end
                end
                uos_pkg::ST_BOOT_SLOW: begin
                    if (restore_done) begin
                        r_next.state = uos_pkg::ST_IDLE_OSCILLATOR;
                    end
                end
                uos_pkg::ST_IDLE_OSCILLATOR: begin
                    if (auto_idle_after_boot && r_reg.xt_ready) begin
                        r_next.state = uos_pkg::ST_PLL_WAIT;
                    end else if (cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_SLEEP)) begin
                        r_next.state = uos_pkg::ST_SLEEP;
                    end else if (cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_DEEP_DOZE)) begin
                        r_next.state = uos_pkg::ST_DEEP_DOZE;
                    end
                end
                uos_pkg::ST_PLL_WAIT: begin
                    if (!auto_idle_after_boot) begin
                        r_next.state = uos_pkg::ST_IDLE_OSCILLATOR;
                    end else if (pll_locked) begin
                        r_next.state = uos_pkg::ST_IDLE_PLL;
                    end
                end
                uos_pkg::ST_IDLE_PLL: begin
                    r_next.delayed = 1'b0;
                    if (cmd_valid) begin
                        case (cmd_code)
                            uos_pkg::CMD_TX_NOW: r_next.state = uos_pkg::ST_TX_WAIT;
                            uos_pkg::CMD_DELAYED_TX: begin
                                r_next.state = uos_pkg::ST_TX_WAIT;
                                r_next.delayed = 1'b1;
                            end
                            uos_pkg::CMD_RX_ENABLE: r_next.state = uos_pkg::ST_RX_WAIT;
                            uos_pkg::CMD_DELAYED_RX: begin
                                r_next.state = uos_pkg::ST_RX_WAIT;
                                r_next.delayed = 1'b1;
                            end
                            uos_pkg::CMD_SLEEP: r_next.state = uos_pkg::ST_SLEEP;
                            uos_pkg::CMD_DEEP_DOZE: r_next.state = uos_pkg::ST_DEEP_DOZE;
                            default: r_next.state = r_reg.state;
                        endcase
                    end
                end
                uos_pkg::ST_TX_WAIT: begin
                    if (cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_TRX_OFF)) begin
                        r_next.state = uos_pkg::ST_IDLE_PLL;
                    end else if (tx_blocks_ready && (!r_reg.delayed || delay_expired)) begin
                        r_next.state = uos_pkg::ST_TX;
                    end
                end
                uos_pkg::ST_TX: begin
                    if (tx_done || cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_TRX_OFF)) begin
                        r_next.state = uos_pkg::ST_IDLE_PLL;
                    end
                end
                uos_pkg::ST_RX_WAIT: begin
                    if (cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_TRX_OFF)) begin
                        r_next.state = uos_pkg::ST_IDLE_PLL;
                    end else if (rx_blocks_ready && (!r_reg.delayed || delay_expired)) begin
                        r_next.state = uos_pkg::ST_RX;
                    end
                end
                uos_pkg::ST_RX: begin
                    if (rx_packet_done || rx_timeout
                        || cmd_is(cmd_valid, cmd_code, uos_pkg::CMD_TRX_OFF)) begin
                        r_next.state = uos_pkg::ST_IDLE_PLL;
                    end
                end
                uos_pkg::ST_SLEEP: begin
                    // Counts slow-RC ticks; the fast clock only samples the tick.
                    if (slow_tick) begin
                        r_next.sleep_cnt = r_reg.sleep_cnt + 16'h0001;
                    end
                    if (r_reg.sleep_cnt >= sleep_terminal || !host_select_n || wakeup_pin) begin
                        r_next.state = uos_pkg::ST_BOOT_SLOW;
                    end
                end
                uos_pkg::ST_DEEP_DOZE: begin
                    if (wakeup_pin || !host_select_n || !device_reset_n) begin
                        r_next.state = uos_pkg::ST_BOOT_SLOW;
                    end
                end
                default: r_next.state = uos_pkg::ST_OFF;
            endcase
        end
        if (r_next.state != uos_pkg::ST_SLEEP) begin
            r_next.sleep_cnt = '0;
        end
        // Outputs decoded from the next state so every port is a flop.
        r_next.state_out = 4'(r_next.state);
        r_next.core_power_en = r_next.state != uos_pkg::ST_OFF;
        r_next.core_reset_n = r_next.state != uos_pkg::ST_OFF;
        r_next.host_link_slow = r_next.state == uos_pkg::ST_BOOT_SLOW;
        r_next.store_download = r_next.state == uos_pkg::ST_BOOT_SLOW;
        r_next.pll_en = (r_next.state inside {uos_pkg::ST_PLL_WAIT, uos_pkg::ST_IDLE_PLL,
            uos_pkg::ST_TX_WAIT, uos_pkg::ST_TX, uos_pkg::ST_RX_WAIT, uos_pkg::ST_RX});
        r_next.tx_power_en = r_next.state inside {uos_pkg::ST_TX_WAIT, uos_pkg::ST_TX};
        r_next.tx_active = r_next.state == uos_pkg::ST_TX;
        r_next.rx_power_en = r_next.state inside {uos_pkg::ST_RX_WAIT, uos_pkg::ST_RX};
        r_next.rx_active = r_next.state == uos_pkg::ST_RX;
        r_next.sleep_counter_en = r_next.state == uos_pkg::ST_SLEEP;
        case (r_next.state)
            uos_pkg::ST_OFF, uos_pkg::ST_DEEP_DOZE: r_next.clk_select = uos_pkg::CLK_NONE;
            uos_pkg::ST_BOOT_SLOW, uos_pkg::ST_IDLE_OSCILLATOR, uos_pkg::ST_PLL_WAIT:
                r_next.clk_select = uos_pkg::CLK_FAST_OSCILLATOR;
            uos_pkg::ST_SLEEP: r_next.clk_select = uos_pkg::CLK_SLOW_RC;
            default: r_next.clk_select = uos_pkg::CLK_PLL;
        endcase
    end

    // --------------------------------------------------------------------
    // State register
    // --------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '{state: uos_pkg::ST_OFF, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign state_out = r_reg.state_out;
    assign core_power_en = r_reg.core_power_en;
    assign regulator_en = r_reg.core_power_en;
    assign core_reset_n = r_reg.core_reset_n;
    assign always_on_reset_n = r_reg.aon_released;
    assign external_enable_out = r_reg.ext_en;
    assign fast_oscillator_en = r_reg.aon_released;
    assign xtal_en = r_reg.aon_released;
    assign clk_select = r_reg.clk_select;
    assign host_link_slow = r_reg.host_link_slow;
    assign store_download = r_reg.store_download;
    assign pll_en = r_reg.pll_en;
    assign tx_power_en = r_reg.tx_power_en;
    assign tx_active = r_reg.tx_active;
    assign rx_power_en = r_reg.rx_power_en;
    assign rx_active = r_reg.rx_active;
    assign sleep_counter_en = r_reg.sleep_counter_en;
    assign fast_oscillator_ready = r_reg.rc_ready;
    assign xtal_ready = r_reg.xt_ready;
endmodule // uos_sequencer
